/* File: cal_seq_pkg.sv */
// Behaviour
// - Mode code 101 enters background calibration on the selected channel.
// - Background mode zero-calibrates at selected gain with inputs shorted internally.
// - Background mode stretches conversions so word rate falls to one sixth.
// - Background mode interleaves calibration cycles with ordinary conversions.
// - Background calibration results update the offset coefficient register without host action.
// - Mode code 110 starts one zero-scale self-calibration on selected channel.
// - Zero-scale self-calibration runs at selected gain with inputs shorted internally.
// - Mode code 111 starts one full-scale self-calibration on selected channel.
// - Full-scale self-calibration uses internal reference divided by selected gain.
// - After a one-step self-calibration the mode field clears to 000 itself.
// - Zero-scale start raises ready_n; low again when valid word is stored.
// - Full-scale start raises ready_n; low only when new valid word is stored.
package cal_seq_pkg;
  localparam int ADDR_W      = 3;
  localparam int DATA_W      = 32;
  localparam int WORD_W      = 24;
  localparam int IRQ_W       = 3;
  localparam int BG_SLOTS    = 6;
  localparam int CONV_CYCLES = 64;

  localparam logic [ADDR_W-1:0] REG_MODE     = 3'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 3'h1;
  localparam logic [ADDR_W-1:0] REG_DATA     = 3'h2;
  localparam logic [ADDR_W-1:0] REG_OFFSET   = 3'h3;
  localparam logic [ADDR_W-1:0] REG_GAIN     = 3'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 3'h5;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 3'h6;

  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_BG     = 3'h5;
  localparam logic [2:0] MODE_ZCAL   = 3'h6;
  localparam logic [2:0] MODE_FCAL   = 3'h7;

  localparam int MODE_LSB = 0;
  localparam int CHAN_LSB = 3;

  localparam int IRQ_WORD = 0;
  localparam int IRQ_CAL  = 1;
  localparam int IRQ_COEF = 2;

  localparam logic [2:0]        MODE_RST   = 3'h0;
  localparam logic [2:0]        CHAN_RST   = 3'h0;
  localparam logic [WORD_W-1:0] WORD_RST   = 24'h000000;
  localparam logic [WORD_W-1:0] GAIN_RST   = 24'h800000;
  localparam logic [IRQ_W-1:0]  IRQ_RST    = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_RST  = 32'h00000000;

  typedef enum logic [2:0] {ST_IDLE, ST_ZCAL, ST_FCAL, ST_POSTCONV, ST_BG} seq_state_t;
endpackage

/* File: pacer_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pacer_if;
  logic       ce;
  logic       run;
  logic       restart;
  logic       bg;
  logic       tick;
  logic [2:0] slot;
  modport seq   (output ce, output run, output restart, output bg, input tick, input slot);
  modport pacer (input ce, input run, input restart, input bg, output tick, output slot);
endinterface
`default_nettype wire

/* File: cal_pacer.sv */
`timescale 1ns/1ps
`default_nettype none
module cal_pacer #(
  parameter int CONV_CYCLES = cal_seq_pkg::CONV_CYCLES  // Cycles per filter period
) (
  input  wire logic i_sys_clk,  // System clock
  input  wire logic i_rst,      // Synchronous reset
  pacer_if.pacer    pif         // Sequencer side
);
  import cal_seq_pkg::*;

  logic [15:0] cnt_r;
  logic        last;

  assign last     = (cnt_r == 16'(CONV_CYCLES - 1));
  assign pif.tick = pif.ce && pif.run && !pif.restart && last;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_r <= 16'h0000;
    end else if (pif.ce) begin
      if (!pif.run || pif.restart || last) begin
        cnt_r <= 16'h0000;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  // Six periods per word in background mode: five calibration, one conversion
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pif.slot <= 3'h0;
    end else if (pif.ce) begin
      if (!pif.run || pif.restart || !pif.bg) begin
        pif.slot <= 3'h0;
      end else if (pif.tick) begin
        pif.slot <= (pif.slot == 3'(BG_SLOTS - 1)) ? 3'h0 : pif.slot + 3'h1;
      end
    end
  end

  a_bg_slot_wrap: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    pif.tick && pif.bg && pif.slot == 3'(BG_SLOTS - 1) |=> pif.slot == 3'h0)
    else $error("background slot did not wrap after sixth period");

  a_bg_slot_step: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    pif.tick && pif.bg && pif.slot < 3'(BG_SLOTS - 1) |=> pif.slot == $past(pif.slot) + 3'h1)
    else $error("background slot did not advance");
endmodule
`default_nettype wire

/* File: cal_mode_seq.sv */
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cal_mode_seq #(
  parameter int CONV_CYCLES = cal_seq_pkg::CONV_CYCLES  // Cycles per filter period
) (
  input  wire logic                            i_sys_clk,           // 100 MHz clock
  input  wire logic                            i_rst,               // Sync reset, high
  input  wire logic                            i_ce,                // Clock enable
  input  wire logic [cal_seq_pkg::ADDR_W-1:0]  i_addr,              // Register index
  input  wire logic [cal_seq_pkg::DATA_W-1:0]  i_wdata,             // Write data
  input  wire logic                            i_wr,                // Write strobe
  input  wire logic                            i_rd,                // Read strobe
  output logic      [cal_seq_pkg::DATA_W-1:0]  o_rdata,             // Read data, next cycle
  input  wire logic [cal_seq_pkg::WORD_W-1:0]  i_filter_word,       // Filter result
  output logic                                 o_conv_word_ready_n, // Word ready, low
  output logic                                 o_irq,               // Interrupt level
  output logic                                 o_short_inputs,      // Inputs shorted
  output logic                                 o_fs_ref_input,      // Vref/gain applied
  output logic      [2:0]                      o_chan_sel,          // Active channel
  output logic                                 o_conv_run           // Modulator running
);
  import cal_seq_pkg::*;

  pacer_if pif ();

  seq_state_t         state_r;
  seq_state_t         state_nxt;
  logic [2:0]         op_mode_r;
  logic [2:0]         chan_sel_r;
  logic [WORD_W-1:0]  data_r;
  logic [WORD_W-1:0]  offset_r;
  logic [WORD_W-1:0]  gain_r;
  logic [IRQ_W-1:0]   irq_stat_r;
  logic [IRQ_W-1:0]   irq_mask_r;
  logic [IRQ_W-1:0]   irq_set;
  logic [DATA_W-1:0]  rdata_r;
  logic               ready_n_r;
  logic               cmd_wr;
  logic [2:0]         cmd_mode;
  logic               bg_conv_slot;
  logic               cal_done;
  logic               word_done;
  logic               coef_upd;

  function automatic logic is_self_cal(input logic [2:0] m);
    return (m == MODE_ZCAL) || (m == MODE_FCAL);
  endfunction

  function automatic seq_state_t mode_state(input logic [2:0] m);
    unique case (m)
      MODE_BG:   return ST_BG;
      MODE_ZCAL: return ST_ZCAL;
      MODE_FCAL: return ST_FCAL;
      default:   return ST_IDLE;
    endcase
  endfunction

  assign cmd_wr       = i_ce && i_wr && (i_addr == REG_MODE);
  assign cmd_mode     = i_wdata[MODE_LSB +: 3];
  assign bg_conv_slot = (pif.slot == 3'(BG_SLOTS - 1));
  assign cal_done     = pif.tick && !cmd_wr && (state_r == ST_ZCAL || state_r == ST_FCAL);
  assign word_done    = pif.tick && !cmd_wr
                        && (state_r == ST_POSTCONV || (state_r == ST_BG && bg_conv_slot));
  assign coef_upd     = pif.tick && !cmd_wr && state_r == ST_BG && !bg_conv_slot;

  // A mode write restarts the pacer so a new command never inherits a half period
  assign pif.ce      = i_ce;
  assign pif.run     = (state_r != ST_IDLE);
  assign pif.restart = cmd_wr;
  assign pif.bg      = (state_r == ST_BG);

  cal_pacer #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_pacer (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .pif       (pif.pacer)
  );

  always_comb begin
    state_nxt = state_r;
    if (cmd_wr) begin
      state_nxt = mode_state(cmd_mode);
    end else if (pif.tick) begin
      unique case (state_r)
        ST_ZCAL:     state_nxt = ST_POSTCONV;
        ST_FCAL:     state_nxt = ST_POSTCONV;
        ST_POSTCONV: state_nxt = ST_IDLE;
        ST_BG:       state_nxt = ST_BG;
        default:     state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  // Host write wins over the self-clear arriving in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      op_mode_r  <= MODE_RST;
      chan_sel_r <= CHAN_RST;
    end else if (cmd_wr) begin
      op_mode_r  <= cmd_mode;
      chan_sel_r <= i_wdata[CHAN_LSB +: 3];
    end else if (cal_done) begin
      op_mode_r <= MODE_NORMAL;
    end
  end

  // Zero-scale results land in the offset word, full-scale in the gain word
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      offset_r <= WORD_RST;
      gain_r   <= GAIN_RST;
    end else if (i_ce) begin
      if ((cal_done && state_r == ST_ZCAL) || coef_upd) begin
        offset_r <= i_filter_word;
      end
      if (cal_done && state_r == ST_FCAL) begin
        gain_r <= i_filter_word;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      data_r <= WORD_RST;
    end else if (word_done) begin
      data_r <= i_filter_word;
    end
  end

  // Ready goes inactive at self-cal start; reading the word also retires it
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ready_n_r <= 1'b1;
    end else if (i_ce) begin
      if (cmd_wr && is_self_cal(cmd_mode)) begin
        ready_n_r <= 1'b1;
      end else if (word_done) begin
        ready_n_r <= 1'b0;
      end else if (i_rd && i_addr == REG_DATA) begin
        ready_n_r <= 1'b1;
      end
    end
  end

  assign irq_set[IRQ_WORD] = word_done;
  assign irq_set[IRQ_CAL]  = cal_done;
  assign irq_set[IRQ_COEF] = coef_upd;

  // Set beats the write-one clear so no event is lost
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      irq_stat_r <= IRQ_RST;
      irq_mask_r <= IRQ_RST;
    end else if (i_ce) begin
      if (i_wr && i_addr == REG_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~i_wdata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
      if (i_wr && i_addr == REG_IRQ_MASK) begin
        irq_mask_r <= i_wdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_r <= RDATA_RST;
    end else if (i_ce) begin
      rdata_r <= RDATA_RST;
      if (i_rd) begin
        unique case (i_addr)
          REG_MODE:     rdata_r <= {26'h0, chan_sel_r, op_mode_r};
          REG_STATUS:   rdata_r <= {27'h0, state_r, pif.run, ready_n_r};
          REG_DATA:     rdata_r <= {8'h00, data_r};
          REG_OFFSET:   rdata_r <= {8'h00, offset_r};
          REG_GAIN:     rdata_r <= {8'h00, gain_r};
          REG_IRQ_STAT: rdata_r <= {29'h0, irq_stat_r};
          REG_IRQ_MASK: rdata_r <= {29'h0, irq_mask_r};
          default:      rdata_r <= RDATA_RST;
        endcase
      end
    end
  end

  assign o_rdata             = rdata_r;
  assign o_conv_word_ready_n = ready_n_r;
  assign o_irq               = |(irq_stat_r & irq_mask_r);
  assign o_chan_sel          = chan_sel_r;
  assign o_conv_run          = pif.run;
  assign o_short_inputs      = (state_r == ST_ZCAL) || (state_r == ST_BG && !bg_conv_slot);
  assign o_fs_ref_input      = (state_r == ST_FCAL);

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_bg_mode_entry: assert property (
    cmd_wr && cmd_mode == MODE_BG |=> state_r == ST_BG && o_chan_sel == $past(i_wdata[5:3]))
    else $error("background mode not entered on selected channel");

  a_bg_zero_short: assert property (
    state_r == ST_BG && pif.slot != 3'(BG_SLOTS - 1) |-> o_short_inputs && !o_fs_ref_input)
    else $error("background zero calibration without shorted inputs");

  a_bg_word_rate: assert property (
    word_done && state_r == ST_BG |-> pif.slot == 3'(BG_SLOTS - 1))
    else $error("background word outside the sixth period");

  // A data read may still retire ready during a calibration period
  a_bg_interleave: assert property (
    coef_upd |=> $stable(data_r) && !$fell(ready_n_r))
    else $error("calibration period disturbed conversion word");

  a_bg_coef_auto: assert property (
    coef_upd |=> offset_r == $past(i_filter_word))
    else $error("background offset coefficient not updated");

  a_zcal_start: assert property (
    cmd_wr && cmd_mode == MODE_ZCAL |=> state_r == ST_ZCAL)
    else $error("zero-scale self calibration not started");

  a_zcal_shorted: assert property (
    state_r == ST_ZCAL |-> o_short_inputs && !o_fs_ref_input)
    else $error("zero-scale calibration inputs not shorted");

  a_fcal_start: assert property (
    cmd_wr && cmd_mode == MODE_FCAL |=> state_r == ST_FCAL)
    else $error("full-scale self calibration not started");

  a_fcal_ref_input: assert property (
    state_r == ST_FCAL |-> o_fs_ref_input && !o_short_inputs)
    else $error("full-scale calibration lacks reference input");

  a_mode_self_clear: assert property (
    cal_done |=> op_mode_r == MODE_NORMAL && state_r == ST_POSTCONV)
    else $error("mode field not cleared after self calibration");

  a_zcal_ready_cycle: assert property (
    cmd_wr && cmd_mode == MODE_ZCAL |=> o_conv_word_ready_n throughout
      (state_r == ST_ZCAL ##1 !word_done [*2]))
    else $error("ready dropped during zero-scale calibration");

  a_fcal_ready_hold: assert property (
    state_r == ST_FCAL |-> o_conv_word_ready_n)
    else $error("ready low during full-scale calibration");

  a_word_ready_low: assert property (
    word_done && state_r == ST_POSTCONV |=> !o_conv_word_ready_n && data_r == $past(i_filter_word))
    else $error("ready not low with new word after calibration");

  a_bg_persist: assert property (
    i_ce && state_r == ST_BG && !cmd_wr |=> state_r == ST_BG && op_mode_r == MODE_BG)
    else $error("background mode left without host write");

  a_cmd_fields: assert property (
    cmd_wr |=> op_mode_r == $past(cmd_mode) && o_chan_sel == $past(i_wdata[CHAN_LSB +: 3]))
    else $error("mode write did not load mode and channel");

  a_bg_gain_kept: assert property (
    state_r == ST_BG |=> $stable(gain_r))
    else $error("gain coefficient changed in background mode");

  a_bg_word_load: assert property (
    word_done && state_r == ST_BG |=> !o_conv_word_ready_n && data_r == $past(i_filter_word))
    else $error("background word not loaded with ready low");

  a_bg_conv_open: assert property (
    state_r == ST_BG && bg_conv_slot |-> !o_short_inputs && !o_fs_ref_input)
    else $error("background conversion period with calibration input");

  a_coef_irq_set: assert property (
    coef_upd |=> irq_stat_r[IRQ_COEF])
    else $error("background offset update not flagged");

  a_zcal_offset_load: assert property (
    cal_done && state_r == ST_ZCAL |=> offset_r == $past(i_filter_word) && $stable(gain_r))
    else $error("zero-scale result not stored as offset");

  a_fcal_gain_load: assert property (
    cal_done && state_r == ST_FCAL |=> gain_r == $past(i_filter_word) && $stable(offset_r))
    else $error("full-scale result not stored as gain");

  a_cal_irq_set: assert property (
    cal_done |=> irq_stat_r[IRQ_CAL])
    else $error("self calibration done not flagged");

  a_self_cal_end: assert property (
    state_r == ST_POSTCONV && pif.tick && !cmd_wr |=> state_r == ST_IDLE && !o_conv_run)
    else $error("one-step calibration did not return to idle");

  a_selfcal_ready_high: assert property (
    cmd_wr && is_self_cal(cmd_mode) |=> o_conv_word_ready_n)
    else $error("ready not raised at self calibration start");

  a_postconv_ready_high: assert property (
    state_r == ST_POSTCONV |-> o_conv_word_ready_n)
    else $error("ready low before calibration word stored");
endmodule
`default_nettype wire

/* File: front_end_model.sv */
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
  input  wire logic        i_short_inputs, // Inputs shorted
  input  wire logic        i_fs_ref_input, // Vref/gain applied
  input  wire logic [2:0]  i_chan_sel,     // Selected channel
  output logic      [23:0] o_word          // Filter result
);
  // One pattern per input source, so a capture from the wrong phase shows
  always_comb begin
    if (i_short_inputs) begin
      o_word = 24'h010000 | {21'h000000, i_chan_sel};
    end else if (i_fs_ref_input) begin
      o_word = 24'h020000 | {21'h000000, i_chan_sel};
    end else begin
      o_word = 24'h030000 | {21'h000000, i_chan_sel};
    end
  end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cal_seq_pkg::*;
  localparam int P = 4;
  logic              i_sys_clk;
  logic              i_rst;
  logic              i_ce;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic              i_wr;
  logic              i_rd;
  logic [DATA_W-1:0] o_rdata;
  logic [WORD_W-1:0] i_filter_word;
  logic              o_conv_word_ready_n;
  logic              o_irq;
  logic              o_short_inputs;
  logic              o_fs_ref_input;
  logic [2:0]        o_chan_sel;
  logic              o_conv_run;
  logic [DATA_W-1:0] rv;
  int                error_cnt;
  int                compares;
  int                cyc;
  int                n;

  cal_mode_seq #(.CONV_CYCLES(P)) i_dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_filter_word(i_filter_word), .o_conv_word_ready_n(o_conv_word_ready_n),
    .o_irq(o_irq), .o_short_inputs(o_short_inputs), .o_fs_ref_input(o_fs_ref_input),
    .o_chan_sel(o_chan_sel), .o_conv_run(o_conv_run));

  front_end_model i_fe (
    .i_short_inputs(o_short_inputs), .i_fs_ref_input(o_fs_ref_input),
    .i_chan_sel(o_chan_sel), .o_word(i_filter_word));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic report_and_stop;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard: whole sequence needs well under two hundred cycles
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Idle cycle before each strobe keeps one assignment per signal per step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (o_conv_word_ready_n !== 1'b0 && cnt < 200) begin
      @(posedge i_sys_clk);
      #1;
      cnt = cnt + 1;
    end
  endtask

  task automatic selfcal(input logic [2:0] code, input logic [2:0] ch,
                         input logic [ADDR_W-1:0] coef, input logic [DATA_W-1:0] cw);
    wr(REG_MODE, {26'h0000000, ch, code});
    #1;
    chk("short", o_short_inputs, code == MODE_ZCAL);
    chk("fsref", o_fs_ref_input, code == MODE_FCAL);
    chk("chan", o_chan_sel, ch);
    chk("ready_n start", o_conv_word_ready_n, 1'b1);
    wait_ready(n);
    chk("cal time", 32'(n), 32'(2 * P));
    rd(REG_MODE, rv);
    chk("mode clr", rv, {26'h0000000, ch, 3'h0});
    rd(coef, rv);
    chk("coef", rv, cw);
    rd(REG_DATA, rv);
    chk("data", rv, 32'h00030000 | ch);
    chk("ready_n retire", o_conv_word_ready_n, 1'b1);
  endtask

  initial begin
    error_cnt = 0;
    compares  = 0;
    i_rst     = 1'b1;
    i_ce      = 1'b1;
    i_addr    = '0;
    i_wdata   = '0;
    i_wr      = 1'b0;
    i_rd      = 1'b0;
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(REG_STATUS, rv);
    chk("status rst", rv, 32'h00000001);
    rd(REG_GAIN, rv);
    chk("gain rst", rv, 32'h00800000);
    rd(3'h7, rv);
    chk("unmapped", rv, 32'h00000000);
    wr(REG_STATUS, 32'h000000ff);
    rd(REG_STATUS, rv);
    chk("status ro", rv, 32'h00000001);
    // Strobe while clock enable is low must be ignored
    @(posedge i_sys_clk);
    i_ce <= 1'b0;
    wr(REG_MODE, 32'h00000006);
    i_ce <= 1'b1;
    #1;
    chk("ce gate", o_conv_run, 1'b0);
    wr(REG_IRQ_MASK, 32'h00000002);
    selfcal(MODE_ZCAL, 3'h3, REG_OFFSET, 32'h00010003);
    chk("irq up", o_irq, 1'b1);
    rd(REG_IRQ_STAT, rv);
    chk("irq stat", rv, 32'h00000003);
    wr(REG_IRQ_MASK, 32'h00000000);
    #1;
    chk("irq masked", o_irq, 1'b0);
    wr(REG_IRQ_MASK, 32'h00000002);
    wr(REG_IRQ_STAT, 32'h00000003);
    #1;
    chk("irq cleared", o_irq, 1'b0);
    // Full scale first, since background never redoes it
    selfcal(MODE_FCAL, 3'h5, REG_GAIN, 32'h00020005);
    wr(REG_IRQ_STAT, 32'h00000007);
    wr(REG_MODE, 32'h00000015);
    #1;
    chk("bg short", o_short_inputs, 1'b1);
    chk("bg chan", o_chan_sel, 3'h2);
    wait_ready(n);
    chk("bg word time", 32'(n), 32'(6 * P));
    rd(REG_OFFSET, rv);
    chk("bg offset", rv, 32'h00010002);
    rd(REG_IRQ_STAT, rv);
    chk("bg irq", rv, 32'h00000005);
    rd(REG_MODE, rv);
    chk("bg mode kept", rv, 32'h00000015);
    rd(REG_DATA, rv);
    chk("bg data", rv, 32'h00030002);
    wait_ready(n);
    chk("bg next word", 32'(n <= 6 * P), 32'h00000001);
    wr(REG_MODE, 32'h00000000);
    #1;
    chk("bg exit", o_conv_run, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
